// [tw_host_pkg.sv]
// Constants for the two-wire host controller of a clock/calendar slave.
// Assumes a 100 MHz core clock and an APB master on the register side.
package tw_host_pkg;
    // ----------------------------------------
    // Register map of the controller (APB)
    // ----------------------------------------
    localparam logic [7:0] CTRL_OFS    = 8'h00;
    localparam logic [7:0] ADDR_OFS    = 8'h04;
    localparam logic [7:0] TXDATA_OFS  = 8'h08;
    localparam logic [7:0] STATUS_OFS  = 8'h0c;
    localparam logic [7:0] RXDATA_OFS  = 8'h10;
    localparam logic [7:0] DIV_OFS     = 8'h14;
    // CTRL fields
    localparam int CTRL_GO_BIT    = 0;
    localparam int CTRL_RD_BIT    = 1;
    localparam int CTRL_CCR_BIT   = 2;
    localparam int CTRL_NOADR_BIT = 3;
    localparam int CTRL_LEN_LSB   = 4;
    localparam int CTRL_LEN_W     = 3;
    localparam int CTRL_NOSTP_BIT = 7;
    // STATUS fields
    localparam int STAT_BUSY_BIT  = 0;
    localparam int STAT_NACK_BIT  = 1;
    localparam int STAT_DONE_BIT  = 2;
    // ----------------------------------------
    // Slave byte and status register values
    // ----------------------------------------
    localparam logic [3:0] ID_ARRAY    = 4'ha;
    localparam logic [3:0] ID_CCR      = 4'hd;
    localparam logic [2:0] SEL_BITS    = 3'h7;
    localparam logic [15:0] STATUS_REG_ADDR = 16'h003f;
    localparam logic [7:0] SR_SET_WEL  = 8'h02;
    localparam logic [7:0] SR_SET_REGISTER_WRITE_LATCH = 8'h06;
    localparam logic [7:0] SR_CLEAR    = 8'h00;
    localparam int MAX_LEN = 8;
    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLK_MHZ = 100;
    localparam logic [15:0] DIV_RESET = 16'd63;  // Quarter bit of about 400 kHz
    localparam int NV_WRITE_MS = 10;
    localparam int NV_WRITE_CYC = NV_WRITE_MS * 1000 * CLK_MHZ;
endpackage

// [tw_pin_sync.sv]
// Three-stage synchroniser with agreement filter for one bus pin.
// Assumes the pin is asynchronous to CORE_CLK_IN.
`timescale 1ns/1ps
module tw_pin_sync (
    input  wire logic clk_in,
    input  wire logic rst_in,
    input  wire logic pin_in,
    output logic      level_out
);
    logic s1_ff;
    logic s2_ff;
    logic s3_ff;
    // A change counts once stages two and three agree
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            s1_ff     <= 1'b1;
            s2_ff     <= 1'b1;
            s3_ff     <= 1'b1;
            level_out <= 1'b1;
        end else begin
            s1_ff <= pin_in;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            if (s2_ff == s3_ff) begin
                level_out <= s3_ff;
            end
        end
    end
endmodule // tw_pin_sync

// [tw_host.sv]
// Two-wire bus master for a clock/calendar slave, ordered over APB.
// Assumes open-drain SCL/SDA with external pull-ups; pins resolved by the bench.
//
// Overview of operation
// RQ1: Enable step one writes 02h to the status register, own transfer.
// RQ2: Enable step two writes 06h to the status register, own transfer.
// RQ3: Then one to eight bytes to control space, slave byte 11011110, stop.
// RQ4: Device runs a nonvolatile write up to 10 ms after that.
// RQ5: Device discards writes to undefined control space locations.
// RQ6: Device clears register write latch when nonvolatile write ends.
// RQ7: Aborted control write leaves register write latch set.
// RQ8: Writing zero to status register clears both latches.
// RQ9: Reads between sequence steps leave latches and progress unchanged.
// RQ10: Only the master starts transfers and drives the serial clock.
// RQ11: SDA changes only while SCL low, except start and stop.
// RQ12: Device ignores traffic until it sees a start condition.
// RQ13: Every transfer ends in a stop after the transmitter releases SDA; the host sends none when CTRL_NOSTP_BIT is set.
// RQ14: After eight bits the transmitter releases SDA; receiver acks ninth clock.
// RQ15: Device nacks bad slave byte, writes with latch clear, second status byte.
// RQ16: Read bytes continue on ack; master nacks last then stops.
// RQ17: Upper slave nibble 1010 selects array, 1101 control space.
// RQ18: Slave bits 3 to 1 are 111; bit 0 set means read.
// RQ19: Device acks only slave bytes matching 1010111 or 1101111.
// RQ20: Two-byte word address follows slave byte, or internal counter used.
// RQ21: Random read repeats the same slave byte in dummy write and read.
// RQ22: First address byte holds bits 14..8, top zero; MSB first.
// RQ23: Device withholds ack during a nonvolatile write cycle.
// RQ24: Status register at 003Fh; bit 2 register latch, bit 1 enable latch.
// RQ25: Pins are synchronised and filtered into the core clock domain.
//
// Added by the designer: the address map and the APB slave port.
`timescale 1ns/1ps
module tw_host (
    input  wire logic        CORE_CLK_IN,
    input  wire logic        RESET_IN,
    input  wire logic        PSEL_IN,
    input  wire logic        PENABLE_IN,
    input  wire logic        PWRITE_IN,
    input  wire logic [7:0]  PADDR_IN,
    input  wire logic [31:0] PWDATA_IN,
    output logic      [31:0] PRDATA_OUT,
    output logic             PREADY_OUT,
    output logic             PSLVERR_OUT,
    input  wire logic        SCL_IN,
    output logic             SCL_OUT,
    output logic             SCL_OE_OUT,
    input  wire logic        SDA_IN,
    output logic             SDA_OUT,
    output logic             SDA_OE_OUT
);
    // ----------------------------------------
    // Types and state
    // ----------------------------------------
    typedef enum {ST_IDLE, ST_START, ST_BIT, ST_ACK, ST_RSTART, ST_STOP} state_e;
    typedef enum {PH_SLAVE, PH_AHI, PH_ALO, PH_WDATA, PH_RSLAVE, PH_RDATA} phase_e;

    state_e            state_ff;
    phase_e            phase_ff;
    logic [1:0]        quarter_ff;
    logic [15:0]       tick_cnt_ff;
    logic [15:0]       div_ff;
    logic [3:0]        bit_cnt_ff;
    logic [7:0]        shift_ff;
    logic [7:0]        ctrl_ff;
    logic [15:0]       word_addr_ff;
    logic [7:0]        txdata_ff [tw_host_pkg::MAX_LEN];
    logic [7:0]        rxdata_ff [tw_host_pkg::MAX_LEN];
    logic [2:0]        byte_idx_ff;
    logic              busy_ff;
    logic              nack_ff;
    logic              done_ff;
    logic              scl_s;
    logic              sda_s;

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    tw_pin_sync u_scl_sync (.clk_in(CORE_CLK_IN), .rst_in(RESET_IN), .pin_in(SCL_IN),
                            .level_out(scl_s));  // RQ25
    tw_pin_sync u_sda_sync (.clk_in(CORE_CLK_IN), .rst_in(RESET_IN), .pin_in(SDA_IN),
                            .level_out(sda_s));  // RQ25

    // ----------------------------------------
    // Decode
    // ----------------------------------------
    wire       apb_acc   = PSEL_IN && PENABLE_IN;
    wire       apb_wr    = apb_acc && PWRITE_IN;
    wire       wr_ctrl   = apb_wr && (PADDR_IN == tw_host_pkg::CTRL_OFS);
    wire       wr_addr   = apb_wr && (PADDR_IN == tw_host_pkg::ADDR_OFS);
    wire       wr_div    = apb_wr && (PADDR_IN == tw_host_pkg::DIV_OFS);
    wire       addr_ok   = (PADDR_IN == tw_host_pkg::CTRL_OFS) ||
                           (PADDR_IN == tw_host_pkg::ADDR_OFS) ||
                           (PADDR_IN == tw_host_pkg::TXDATA_OFS) ||
                           (PADDR_IN == tw_host_pkg::STATUS_OFS) ||
                           (PADDR_IN == tw_host_pkg::RXDATA_OFS) ||
                           (PADDR_IN == tw_host_pkg::DIV_OFS);
    wire       start_req = wr_ctrl && PWDATA_IN[tw_host_pkg::CTRL_GO_BIT] && !busy_ff;
    wire       is_rd     = ctrl_ff[tw_host_pkg::CTRL_RD_BIT];
    wire       no_addr   = ctrl_ff[tw_host_pkg::CTRL_NOADR_BIT];
    wire       no_stop   = ctrl_ff[tw_host_pkg::CTRL_NOSTP_BIT];
    wire [2:0] last_idx  = ctrl_ff[tw_host_pkg::CTRL_LEN_LSB +: tw_host_pkg::CTRL_LEN_W];
    // RQ17 RQ18 RQ19 RQ21: same identifier in write and read phases
    wire [3:0] ident     = ctrl_ff[tw_host_pkg::CTRL_CCR_BIT] ? tw_host_pkg::ID_CCR
                                                              : tw_host_pkg::ID_ARRAY;
    wire [7:0] slave_wr  = {ident, tw_host_pkg::SEL_BITS, 1'b0};  // RQ1 RQ2 RQ3
    wire [7:0] slave_rd  = {ident, tw_host_pkg::SEL_BITS, 1'b1};
    wire       tick      = (tick_cnt_ff == div_ff);
    wire       last_byte = (byte_idx_ff == last_idx);
    // TX data lane: TXDATA offset plus index in PWDATA[10:8]
    wire       wr_txd    = apb_wr && (PADDR_IN == tw_host_pkg::TXDATA_OFS);
    wire [2:0] tx_sel    = PWDATA_IN[10:8];
    wire [2:0] rx_sel    = last_idx;
    wire [7:0] rx_rd     = rxdata_ff[rx_sel];

    // ----------------------------------------
    // APB slave, zero wait states
    // ----------------------------------------
    always_ff @(posedge CORE_CLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            PRDATA_OUT  <= 32'h0;
            PREADY_OUT  <= 1'b0;
            PSLVERR_OUT <= 1'b0;
        end else begin
            PREADY_OUT  <= PSEL_IN && !PENABLE_IN;
            PSLVERR_OUT <= PSEL_IN && !PENABLE_IN && !addr_ok;
            case (PADDR_IN)
                tw_host_pkg::CTRL_OFS:   PRDATA_OUT <= {24'h0, ctrl_ff};
                tw_host_pkg::ADDR_OFS:   PRDATA_OUT <= {16'h0, word_addr_ff};
                tw_host_pkg::STATUS_OFS: PRDATA_OUT <= {29'h0, done_ff, nack_ff, busy_ff};
                tw_host_pkg::RXDATA_OFS: PRDATA_OUT <= {rxdata_ff[3], rxdata_ff[2],
                                                        rxdata_ff[1], rxdata_ff[0]};
                tw_host_pkg::DIV_OFS:    PRDATA_OUT <= {16'h0, div_ff};
                default:                 PRDATA_OUT <= {24'h0, rx_rd};
            endcase
        end
    end

    always_ff @(posedge CORE_CLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            ctrl_ff      <= 8'h0;
            word_addr_ff <= 16'h0;
            div_ff       <= tw_host_pkg::DIV_RESET;
        end else begin
            if (wr_ctrl && !busy_ff) begin
                ctrl_ff <= PWDATA_IN[7:0];
            end
            if (wr_addr && !busy_ff) begin
                word_addr_ff <= {1'b0, PWDATA_IN[14:0]};  // RQ22
            end
            if (wr_div && !busy_ff && (PWDATA_IN[15:0] != 16'h0)) begin
                div_ff <= PWDATA_IN[15:0];
            end
        end
    end

    // Transmit buffer, one byte per index
    generate
        for (genvar g = 0; g < tw_host_pkg::MAX_LEN; g++) begin : g_tx
            always_ff @(posedge CORE_CLK_IN or posedge RESET_IN) begin
                if (RESET_IN) begin
                    txdata_ff[g] <= 8'h0;
                end else if (wr_txd && !busy_ff && (tx_sel == 3'(g))) begin
                    txdata_ff[g] <= PWDATA_IN[7:0];
                end
            end
        end
    endgenerate

    // ----------------------------------------
    // Quarter-bit timer
    // ----------------------------------------
    always_ff @(posedge CORE_CLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            tick_cnt_ff <= 16'h0;
        end else if (state_ff == ST_IDLE || tick) begin
            tick_cnt_ff <= 16'h0;
        end else begin
            tick_cnt_ff <= tick_cnt_ff + 16'h1;
        end
    end

    // ----------------------------------------
    // Bus sequencer
    // Each bit is four quarters: 0 SCL low set SDA, 1 SCL rise, 2 sample, 3 SCL fall.
    // ----------------------------------------
    wire [7:0] next_tx = (phase_ff == PH_SLAVE)  ? slave_wr :
                         (phase_ff == PH_AHI)    ? word_addr_ff[15:8] :
                         (phase_ff == PH_ALO)    ? word_addr_ff[7:0] :
                         (phase_ff == PH_RSLAVE) ? slave_rd : txdata_ff[byte_idx_ff];
    wire       rx_phase = (phase_ff == PH_RDATA);

    always_ff @(posedge CORE_CLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            state_ff    <= ST_IDLE;
            phase_ff    <= PH_SLAVE;
            quarter_ff  <= 2'd0;
            bit_cnt_ff  <= 4'd0;
            shift_ff    <= 8'h0;
            byte_idx_ff <= 3'd0;
            busy_ff     <= 1'b0;
            nack_ff     <= 1'b0;
            done_ff     <= 1'b0;
            SCL_OUT     <= 1'b1;
            SCL_OE_OUT  <= 1'b0;
            SDA_OUT     <= 1'b1;
            SDA_OE_OUT  <= 1'b0;
            for (int i = 0; i < tw_host_pkg::MAX_LEN; i++) begin
                rxdata_ff[i] <= 8'h0;
            end
        end else begin
            if (wr_ctrl && PWDATA_IN[tw_host_pkg::STAT_DONE_BIT + 8]) begin
                done_ff <= 1'b0;
            end
            case (state_ff)
                ST_IDLE: begin
                    // Held bus after a stop-less transfer: next one opens with a repeated start
                    if (!no_stop) begin
                        SCL_OE_OUT <= 1'b0;
                        SDA_OE_OUT <= 1'b0;
                    end
                    if (start_req) begin  // RQ10
                        busy_ff     <= 1'b1;
                        nack_ff     <= 1'b0;
                        done_ff     <= 1'b0;
                        byte_idx_ff <= 3'd0;
                        quarter_ff  <= 2'd0;
                        phase_ff    <= (PWDATA_IN[tw_host_pkg::CTRL_RD_BIT] &&
                                        PWDATA_IN[tw_host_pkg::CTRL_NOADR_BIT])
                                       ? PH_RSLAVE : PH_SLAVE;  // RQ20
                        state_ff    <= ST_START;
                    end
                end
                ST_START, ST_RSTART: if (tick) begin
                    quarter_ff <= quarter_ff + 2'd1;
                    case (quarter_ff)
                        2'd0: begin SDA_OE_OUT <= 1'b0; SDA_OUT <= 1'b1; end
                        2'd1: SCL_OE_OUT <= 1'b0;
                        // Fall of SDA while SCL high marks the start
                        2'd2: begin SDA_OE_OUT <= 1'b1; SDA_OUT <= 1'b0; end  // RQ11 RQ12
                        default: begin
                            SCL_OE_OUT <= 1'b1;
                            SCL_OUT    <= 1'b0;
                            shift_ff   <= next_tx;
                            bit_cnt_ff <= 4'd0;
                            state_ff   <= ST_BIT;
                        end
                    endcase
                end
                ST_BIT: if (tick) begin
                    quarter_ff <= quarter_ff + 2'd1;
                    case (quarter_ff)
                        2'd0: begin  // RQ11 RQ22: change SDA only with SCL low, MSB first
                            SDA_OE_OUT <= !rx_phase && !shift_ff[7];
                            SDA_OUT    <= 1'b0;
                        end
                        2'd1: SCL_OE_OUT <= 1'b0;
                        2'd2: if (scl_s) begin
                            shift_ff <= {shift_ff[6:0], sda_s};
                        end else begin
                            quarter_ff <= 2'd2;  // Wait while slave stretches clock
                        end
                        default: begin
                            SCL_OE_OUT <= 1'b1;
                            bit_cnt_ff <= bit_cnt_ff + 4'd1;
                            if (bit_cnt_ff == 4'd7) begin
                                state_ff <= ST_ACK;
                            end
                        end
                    endcase
                end
                ST_ACK: if (tick) begin
                    quarter_ff <= quarter_ff + 2'd1;
                    case (quarter_ff)
                        2'd0: begin  // RQ14 RQ16: release on write, ack reads unless last
                            SDA_OE_OUT <= rx_phase && !last_byte;
                            SDA_OUT    <= 1'b0;
                            if (rx_phase) begin
                                rxdata_ff[byte_idx_ff] <= shift_ff;
                            end
                        end
                        2'd1: SCL_OE_OUT <= 1'b0;
                        2'd2: if (scl_s) begin
                            if (!rx_phase && sda_s) begin  // RQ15 RQ23
                                nack_ff <= 1'b1;
                            end
                        end else begin
                            quarter_ff <= 2'd2;
                        end
                        default: begin
                            SCL_OE_OUT <= 1'b1;
                            bit_cnt_ff <= 4'd0;
                            state_ff   <= ST_BIT;
                            if (nack_ff) begin
                                state_ff <= ST_STOP;
                            end else begin
                                case (phase_ff)
                                    PH_SLAVE: begin
                                        phase_ff <= PH_AHI;
                                        shift_ff <= word_addr_ff[15:8];
                                    end
                                    PH_AHI: begin
                                        phase_ff <= PH_ALO;
                                        shift_ff <= word_addr_ff[7:0];
                                    end
                                    PH_ALO: if (is_rd) begin  // RQ21 repeated start
                                        phase_ff <= PH_RSLAVE;
                                        state_ff <= ST_RSTART;
                                    end else begin
                                        phase_ff <= PH_WDATA;
                                        shift_ff <= txdata_ff[0];
                                    end
                                    PH_RSLAVE: phase_ff <= PH_RDATA;
                                    default: if (last_byte) begin  // RQ3: one to eight bytes
                                        state_ff <= ST_STOP;
                                    end else begin
                                        byte_idx_ff <= byte_idx_ff + 3'd1;
                                        shift_ff    <= txdata_ff[byte_idx_ff + 3'd1];
                                    end
                                endcase
                            end
                        end
                    endcase
                end
                ST_STOP: if (tick) begin
                    quarter_ff <= quarter_ff + 2'd1;
                    case (quarter_ff)
                        2'd0: begin SDA_OE_OUT <= 1'b1; SDA_OUT <= 1'b0; end
                        // SCL kept low when the stop is suppressed, so no stop can form
                        2'd1: SCL_OE_OUT <= no_stop;
                        // RQ13: SDA rises with SCL high; optional hold-off for chained use
                        2'd2: if (!no_stop) begin
                            SDA_OE_OUT <= 1'b0;
                        end
                        default: begin
                            busy_ff  <= 1'b0;
                            done_ff  <= 1'b1;
                            state_ff <= ST_IDLE;
                        end
                    endcase
                end
                default: state_ff <= ST_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    sequence s_scl_high_q;
        !SCL_OE_OUT;
    endsequence

    a_sda_stable_high: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)  // RQ11
        (state_ff == ST_BIT) && !SCL_OE_OUT |=> $stable(SDA_OE_OUT) || SCL_OE_OUT)
        else $error("SDA changed while SCL released");
    a_release_on_ack: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)  // RQ14
        (state_ff == ST_ACK) && !rx_phase && (quarter_ff == 2'd1) |-> !SDA_OE_OUT)
        else $error("SDA driven during write acknowledge");
    a_nack_stops: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)  // RQ15
        (state_ff == ST_ACK) && tick && (quarter_ff == 2'd3) && nack_ff |=> state_ff == ST_STOP)
        else $error("No stop after nack");
    a_stop_ends: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)  // RQ13
        (state_ff == ST_STOP) && tick && (quarter_ff == 2'd3) |=> !busy_ff && done_ff)
        else $error("Stop did not finish transfer");
    a_idle_release: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)  // RQ10
        (state_ff == ST_IDLE) && !no_stop ##1 (state_ff == ST_IDLE) |-> !SCL_OE_OUT && !SDA_OE_OUT)
        else $error("Bus driven while idle");
    a_start_cond: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)  // RQ12
        (state_ff == ST_START) && tick && (quarter_ff == 2'd2) |=> (SDA_OE_OUT and s_scl_high_q))
        else $error("Start not formed with SCL high");
    a_slave_id: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)  // RQ18
        slave_rd[3:1] == tw_host_pkg::SEL_BITS && slave_rd[0] && !slave_wr[0])
        else $error("Slave byte select bits wrong");
    a_last_nack: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)  // RQ16
        (state_ff == ST_ACK) && rx_phase && last_byte && (quarter_ff == 2'd2) |-> !SDA_OE_OUT)
        else $error("Last read byte acknowledged");
endmodule // tw_host

// [tw_dev_model.sv]
// Behavioural clock/calendar slave on the two-wire bus: status register and write gate.
// Assumes resolved open-drain lines with pull-ups; pull_out high pulls SDA low.
`timescale 1ns/1ps
module tw_dev_model #(parameter int NV_NS = 20000) (
    input  wire logic scl_in,
    input  wire logic sda_in,
    output logic      pull_out
);
    logic [7:0]  sh, dat, sr = 8'h00;
    logic        act = 1'b0, rd, busy = 1'b0, ccr_sel, pend = 1'b0;
    logic [15:0] adr = 16'h0000;
    int          cnt, nb;
    initial pull_out = 1'b0;
    always @(negedge sda_in) if (scl_in) begin
        act = 1'b1; cnt = 0; nb = 0; pend = 1'b0;
    end
    always @(posedge sda_in) if (scl_in) begin
        if (act && pend && ccr_sel) begin
            if (adr != 16'h003f) busy = sr[2];
            else if (dat == 8'h00 || dat == 8'h02 || (dat == 8'h06 && sr[1])) sr = dat;
        end
        act = 1'b0;
    end
    // Latch clears when the slow write ends or a 00h/02h status write lands; reads never touch it
    always @(posedge busy) begin
        #(NV_NS);
        sr[2] = 1'b0;
        busy = 1'b0;
    end
    always @(posedge scl_in) if (act) begin
        if (cnt == 8 && rd && nb > 0 && sda_in) act = 1'b0;
        sh = {sh[6:0], sda_in};
        cnt = (cnt == 8) ? 0 : cnt + 1;
    end
    always @(negedge scl_in) if (act) begin
        pull_out = 1'b0;
        if (cnt == 8 && !(rd && nb > 0)) begin
            if (nb == 0) begin
                ccr_sel = (sh[7:4] == 4'hd);
                rd = sh[0];
                pull_out = !busy && (sh[7:1] == 7'h57 || sh[7:1] == 7'h6f);
            end else if (nb < 3) begin
                if (nb == 1) adr[15:8] = sh; else adr[7:0] = sh;
                pull_out = 1'b1;
            end else begin
                pull_out = (adr == 16'h003f) ? (nb == 3) : sr[1];
                if (pull_out) dat = sh;
                pend = pend || pull_out;
            end
            // A refused data byte still waits for the stop that ends the transfer
            act = pull_out || (nb > 2);
            nb++;
        end else if (rd && nb > 0 && cnt < 8)
            pull_out = !((ccr_sel && adr == 16'h003f) ? sr[7 - cnt] : 1'b1);
    end
endmodule // tw_dev_model

// [two_wire_slave_ccr_write_gate_tb_top.sv]
// Bench: APB-driven host against the slave model, enable sequence and write gate.
// Assumes the host's open-drain pins are resolved through the wires below.
`timescale 1ns/1ps
module two_wire_slave_ccr_write_gate_tb_top;
    logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0, err;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd_val, st;
    logic        pready, pslverr, scl_oe, sda_oe, pull, scl_o, sda_o;
    int          n_fail = 0, check_count = 0;
    wire         scl = scl_oe ? scl_o : 1'b1;
    wire         sda = (sda_oe ? sda_o : 1'b1) && !pull;
    always #5 clk = !clk;
    tw_host i_tw_host (.CORE_CLK_IN(clk), .RESET_IN(rst), .PSEL_IN(psel), .PENABLE_IN(pen),
        .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
        .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .SCL_IN(scl), .SCL_OUT(scl_o),
        .SCL_OE_OUT(scl_oe), .SDA_IN(sda), .SDA_OUT(sda_o), .SDA_OE_OUT(sda_oe));
    tw_dev_model #(.NV_NS(20000)) i_tw_dev_model (.scl_in(scl), .sda_in(sda), .pull_out(pull));
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
        int k;
        k = 0;
        psel <= 1'b1; pwr <= wr; paddr <= a; pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1 && ++k < 50);
        rd_val = prdata;
        err = pslverr;
        psel <= 1'b0; pen <= 1'b0;
        @(posedge clk);
        if (k >= 50) begin n_fail++; end_of_test(); end
    endtask
    // Loads bytes and address, starts, polls done, leaves status in st and data in rd_val
    task automatic xfer(logic [7:0] ctl, logic [15:0] a, logic [7:0] b0, logic [7:0] b1);
        int k;
        apb(1, tw_host_pkg::TXDATA_OFS, {24'h0, b0});
        apb(1, tw_host_pkg::TXDATA_OFS, {24'h1, b1});
        apb(1, tw_host_pkg::ADDR_OFS, {16'h0, a});
        apb(1, tw_host_pkg::CTRL_OFS, {24'h4, ctl});
        for (k = 0; k < 400; k++) begin
            apb(0, tw_host_pkg::STATUS_OFS, 32'h0);
            if (rd_val[tw_host_pkg::STAT_DONE_BIT] === 1'b1) break;
            repeat (50) @(posedge clk);
        end
        st = rd_val;
        apb(0, tw_host_pkg::RXDATA_OFS, 32'h0);
        if (k >= 400) begin n_fail++; end_of_test(); end
    endtask
    task automatic sc_enable();
        xfer(8'h05, 16'h003f, 8'h02, 8'h00); check("ack step one", st[1], 0);
        xfer(8'h07, 16'h003f, 8'h00, 8'h00); check("latch one", rd_val[7:0], 8'h02);
        xfer(8'h05, 16'h003f, 8'h06, 8'h00); check("ack step two", st[1], 0);
        xfer(8'h07, 16'h003f, 8'h00, 8'h00); check("latch two", rd_val[7:0], 8'h06);
    endtask
    task automatic sc_abort_write();
        xfer(8'h95, 16'h0030, 8'h11, 8'h22);
        xfer(8'h07, 16'h003f, 8'h00, 8'h00); check("kept", rd_val[7:0], 8'h06);
        xfer(8'h15, 16'h0030, 8'h11, 8'h22); check("ccr ack", st[1], 0);
        xfer(8'h07, 16'h003f, 8'h00, 8'h00); check("busy nack", st[1], 1);
        repeat (2500) @(posedge clk);
        xfer(8'h07, 16'h003f, 8'h00, 8'h00); check("after nv", rd_val[7:0], 8'h02);
    endtask
    task automatic sc_clear();
        xfer(8'h15, 16'h003f, 8'h00, 8'h00); check("second byte", st[1], 1);
        xfer(8'h07, 16'h003f, 8'h00, 8'h00); check("cleared", rd_val[7:0], 8'h00);
        xfer(8'h05, 16'h0031, 8'h55, 8'h00); check("gated", st[1], 1);
    endtask
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        apb(0, tw_host_pkg::DIV_OFS, 32'h0);
        check("div reset", rd_val, {16'h0, tw_host_pkg::DIV_RESET});
        apb(0, 8'h3c, 32'h0);
        check("unmapped", err, 1);
        apb(1, tw_host_pkg::DIV_OFS, 32'h7);
        sc_enable();
        sc_abort_write();
        sc_clear();
        end_of_test();
    end
endmodule // two_wire_slave_ccr_write_gate_tb_top
